//--- src/embp_port.sv
// External memory bus port: phase sequencer, strobes and arbitration
module embp_port (
  // Clock and reset
  input  wire logic                        I_CLK_SYS,
  input  wire logic                        I_SYS_RST,
  // Core request side
  input  wire logic                        I_REQ_VALID,
  input  wire logic                        I_REQ_WRITE,
  input  wire logic                        I_REQ_PROG,
  input  wire logic [embp_pkg::ADDR_W-1:0] I_REQ_ADDR,
  input  wire logic [embp_pkg::DATA_W-1:0] I_REQ_WDATA,
  input  wire logic                        I_REQ_LOCK,
  output logic                             O_REQ_READY,
  output logic                             O_REQ_DONE,
  output logic      [embp_pkg::DATA_W-1:0] O_REQ_RDATA,
  output logic                             O_BUS_WAIT,
  // Configuration and status bits
  input  wire logic [embp_pkg::WAIT_W-1:0] I_WAIT_CNT,
  input  wire logic                        I_MASTER_MODE,
  input  wire logic                        I_REQUEST_HOLD,
  output logic                             O_GRANT_STS,
  // Address and control pins
  output embp_pkg::embp_pins_t             O_PINS,
  output logic                             O_PINS_OE_N,
  // Data bus pins
  input  wire logic [embp_pkg::DATA_W-1:0] I_DATA_BUS,
  output logic      [embp_pkg::DATA_W-1:0] O_DATA_BUS,
  output logic                             O_DATA_BUS_OE_N,
  // Handshake and arbitration pins
  input  wire logic                        I_TRANSFER_ACK_N,
  input  wire logic                        I_BUS_REQUEST_N,
  output logic                             O_BUS_REQUEST_N,
  output logic                             O_BUS_REQUEST_OE_N,
  input  wire logic                        I_BUS_GRANT_N,
  output logic                             O_BUS_GRANT_N,
  output logic                             O_BUS_GRANT_OE_N,
  input  wire logic                        I_BUS_BUSY_N,
  output logic                             O_BUS_BUSY_N,
  output logic                             O_BUS_BUSY_OE_N
);

  // ==========================================================
  // State
  embp_pkg::embp_st_t st_ff;
  embp_pkg::embp_st_t nxt_st;
  logic               ta_lo;
  logic               br_lo;
  logic               bg_lo;
  logic               bb_hi;
  logic               need;
  logic               start;
  logic               ending;

  // Synchronised pin levels, second stage only
  assign ta_lo = !st_ff.ta_s[1];
  assign br_lo = !st_ff.br_s[1];
  assign bg_lo = !st_ff.bg_s[1];
  assign bb_hi = st_ff.bb_s[1];

  // Cycle boundary: new cycle may start here
  assign ending = (st_ff.ph == embp_pkg::PH_IDLE) ||
                  (st_ff.ph == embp_pkg::PH_T3);
  assign need   = I_REQ_VALID || I_REQUEST_HOLD ||
                  (st_ff.ph != embp_pkg::PH_IDLE);

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st        = st_ff;
    start         = 1'b0;
    // Two-flop synchronisers on every pin input
    nxt_st.ta_s   = {st_ff.ta_s[0], I_TRANSFER_ACK_N};
    nxt_st.br_s   = {st_ff.br_s[0], I_BUS_REQUEST_N};
    nxt_st.bg_s   = {st_ff.bg_s[0], I_BUS_GRANT_N};
    nxt_st.bb_s   = {st_ff.bb_s[0], I_BUS_BUSY_N};
    nxt_st.d_s1   = I_DATA_BUS;
    nxt_st.d_s2   = st_ff.d_s1;
    nxt_st.ready  = 1'b0;
    nxt_st.done   = 1'b0;
    nxt_st.cap    = 1'b0;
    nxt_st.gsts   = st_ff.bg_s[1];
    // read capture, two sync stages after end of t2
    if (st_ff.cap) begin
      nxt_st.rdat = st_ff.d_s2;
      nxt_st.done = 1'b1;
    end

    // Arbitration decides mastership before any cycle starts
    if (!I_MASTER_MODE) begin
      nxt_st.br_n = 1'b1;
      // no grant inside an indivisible instruction
      if (!st_ff.grant && br_lo && !I_REQ_LOCK &&
          st_ff.ph == embp_pkg::PH_IDLE) begin
        nxt_st.grant = 1'b1;
        nxt_st.own   = 1'b0;
      end else if (st_ff.grant && !br_lo) begin
        // drop grant when request goes away
        nxt_st.grant = 1'b0;
      end else if (!st_ff.grant && !st_ff.own && bb_hi) begin
        nxt_st.own   = 1'b1;
      end
    end else begin
      nxt_st.grant = 1'b0;
      // request while the bus is needed
      nxt_st.br_n  = !need;
      if (!st_ff.own && bg_lo && bb_hi && !st_ff.br_n) begin
        nxt_st.own = 1'b1;
      end else if (st_ff.own && st_ff.ph == embp_pkg::PH_IDLE &&
                   (!bg_lo || !need)) begin
        nxt_st.own = 1'b0;
      end
      // toggle request after a program fetch
      if (st_ff.ph == embp_pkg::PH_T3 && st_ff.pins.space &&
          !I_REQUEST_HOLD) begin
        nxt_st.br_n = 1'b1;
      end
    end

    unique case (st_ff.ph)
      embp_pkg::PH_IDLE, embp_pkg::PH_T3: begin
        if (st_ff.ph == embp_pkg::PH_T3) begin
          // write data floats in the cycle after t3
          nxt_st.dat_oe_n = 1'b1;
          nxt_st.cap      = st_ff.pins.rw_n;
          nxt_st.done     = !st_ff.pins.rw_n;
        end
        start = ending && I_REQ_VALID && st_ff.own && nxt_st.own;
        if (start) begin
          nxt_st.ph        = embp_pkg::PH_T0;
          nxt_st.pins.addr = I_REQ_ADDR;
          nxt_st.pins.space = I_REQ_PROG;
          nxt_st.pins.rw_n = !I_REQ_WRITE;
          nxt_st.pins.cs_n = 1'b0;
          nxt_st.wdat      = I_REQ_WDATA;
          nxt_st.wcnt      = I_WAIT_CNT;
          nxt_st.ready     = 1'b1;
          if (I_MASTER_MODE) begin
            nxt_st.br_n = 1'b0;
          end
        end else begin
          nxt_st.ph         = embp_pkg::PH_IDLE;
          // space select high without bus use
          nxt_st.pins.space = 1'b1;
          nxt_st.pins.rw_n  = 1'b1;
          nxt_st.pins.cs_n  = 1'b1;
        end
      end
      embp_pkg::PH_T0: begin
        nxt_st.ph = embp_pkg::PH_T1;
        // acknowledge already low at t0, no waits
        nxt_st.zw = ta_lo && (st_ff.wcnt == '0);
        nxt_st.pins.rd_n = !st_ff.pins.rw_n;
        nxt_st.pins.wr_n = st_ff.pins.rw_n;
      end
      embp_pkg::PH_T1, embp_pkg::PH_TW: begin
        if (st_ff.wcnt != '0) begin
          nxt_st.wcnt = st_ff.wcnt - 1'b1;
          nxt_st.ph   = embp_pkg::PH_TW;
        end else if (st_ff.zw || ta_lo) begin
          // acknowledge seen at last wait period
          nxt_st.ph        = embp_pkg::PH_T2;
          nxt_st.pins.cs_n = 1'b1;
          nxt_st.dat_oe_n  = st_ff.pins.rw_n;
        end else begin
          nxt_st.ph = embp_pkg::PH_TW;
        end
      end
      embp_pkg::PH_T2: begin
        nxt_st.ph        = embp_pkg::PH_T3;
        nxt_st.pins.rd_n = 1'b1;
        nxt_st.pins.wr_n = 1'b1;
      end
      default: begin
        nxt_st.ph = embp_pkg::PH_IDLE;
      end
    endcase

    // access stalls while bus is not ours
    nxt_st.bwait    = I_REQ_VALID && !nxt_st.own;
    nxt_st.ctl_oe_n = !nxt_st.own;
    if (!nxt_st.own) begin
      nxt_st.dat_oe_n = 1'b1;
    end
    nxt_st.bb_n     = !nxt_st.own;
    // request pin driven in master mode even before owning
    nxt_st.req_oe_n = !I_MASTER_MODE;
    nxt_st.gnt_oe_n = I_MASTER_MODE;

    if (I_SYS_RST) begin
      nxt_st          = embp_pkg::ST_RST;
      // grant pin direction follows the mode in reset too
      nxt_st.gnt_oe_n = I_MASTER_MODE;
    end
  end

  // ==========================================================
  // Register
  always_ff @(posedge I_CLK_SYS) begin
    st_ff <= nxt_st;
  end

  // ==========================================================
  // Outputs, all from flops
  assign O_REQ_READY        = st_ff.ready;
  assign O_REQ_DONE         = st_ff.done;
  assign O_REQ_RDATA        = st_ff.rdat;
  assign O_BUS_WAIT         = st_ff.bwait;
  assign O_GRANT_STS        = st_ff.gsts;
  assign O_PINS             = st_ff.pins;
  assign O_PINS_OE_N        = st_ff.ctl_oe_n;
  assign O_DATA_BUS         = st_ff.wdat;
  assign O_DATA_BUS_OE_N    = st_ff.dat_oe_n;
  assign O_BUS_REQUEST_N    = st_ff.br_n;
  assign O_BUS_GRANT_N      = !st_ff.grant;
  assign O_BUS_BUSY_N       = st_ff.bb_n;
  // Mode picks which arbitration pin is an output, one cycle late
  assign O_BUS_REQUEST_OE_N = st_ff.req_oe_n;
  assign O_BUS_GRANT_OE_N   = st_ff.gnt_oe_n;
  assign O_BUS_BUSY_OE_N    = st_ff.ctl_oe_n;

  // ==========================================================
  // Checks
  sequence s_cyc_start;
    st_ff.ph == embp_pkg::PH_T0;
  endsequence

  sequence s_strobes_on;
    st_ff.ph == embp_pkg::PH_T1 && !st_ff.pins.cs_n &&
    (st_ff.pins.rd_n != st_ff.pins.wr_n);
  endsequence

  addr_hold_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    (st_ff.ph == embp_pkg::PH_IDLE) ##1
    (st_ff.ph == embp_pkg::PH_IDLE) |-> $stable(st_ff.pins.addr))
    else $error("address moved while idle");
  ctl_float_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    !st_ff.own |-> st_ff.ctl_oe_n && st_ff.dat_oe_n && st_ff.bb_n)
    else $error("pins driven without mastership");
  // write data only in t2 and t3
  data_drive_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    !st_ff.dat_oe_n |-> !st_ff.pins.rw_n &&
    (st_ff.ph == embp_pkg::PH_T2 || st_ff.ph == embp_pkg::PH_T3))
    else $error("data bus driven outside write t2/t3");
  space_idle_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.ph == embp_pkg::PH_IDLE |-> st_ff.pins.space)
    else $error("space select low while idle");
  rw_idle_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.ph == embp_pkg::PH_IDLE |-> st_ff.pins.rw_n)
    else $error("read/write low while idle");
  // cycle strobe through t0 and t1, one of rd/wr low in t1
  cycle_strobe_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    s_cyc_start |-> !st_ff.pins.cs_n ##1 s_strobes_on)
    else $error("cycle strobe or read/write strobe wrong");
  strobe_end_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.ph == embp_pkg::PH_T3 |->
    st_ff.pins.rd_n && st_ff.pins.wr_n && st_ff.pins.cs_n)
    else $error("strobe still low in t3");
  ack_end_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    (st_ff.ph == embp_pkg::PH_TW && st_ff.wcnt == '0 && ta_lo)
    |=> st_ff.ph == embp_pkg::PH_T2 ##1 st_ff.ph == embp_pkg::PH_T3)
    else $error("cycle did not end after acknowledge");
  // grant never during a locked instruction
  grant_lock_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    $rose(st_ff.grant) |-> !$past(I_REQ_LOCK))
    else $error("grant given during indivisible access");
  // no cycle starts without the bus
  stall_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.ready |-> st_ff.own && !st_ff.grant)
    else $error("cycle started without mastership");
  wr_strobe_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.ph == embp_pkg::PH_T1 && !st_ff.pins.rw_n |->
    !st_ff.pins.wr_n && st_ff.pins.rd_n)
    else $error("write strobe wrong in t1");
  // zero-wait cycle goes straight to t2
  zero_wait_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.ph == embp_pkg::PH_T1 && st_ff.zw && st_ff.wcnt == '0
    |=> st_ff.ph == embp_pkg::PH_T2)
    else $error("zero-wait cycle stretched");
  // captured word handed over with done
  rd_capture_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.cap |=> st_ff.done && st_ff.rdat == $past(st_ff.d_s2))
    else $error("read data not handed over");
  grant_float_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.grant |-> st_ff.ctl_oe_n && st_ff.bb_n &&
    st_ff.ph == embp_pkg::PH_IDLE)
    else $error("bus driven while granted away");
  // request low with every master access start
  req_chip_sel_a: assert property (@(posedge I_CLK_SYS)
    disable iff (I_SYS_RST)
    st_ff.ready && I_MASTER_MODE |-> !st_ff.br_n)
    else $error("request not asserted at access start");

endmodule

//--- src/embp_pkg.sv
// Shared types and constants of the external memory bus port
package embp_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int WAIT_W = 4;

  // ==========================================================
  // Bus phases, Gray coded along t0 -> t1 -> t2 -> t3
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_T0   = 3'h1,
    PH_T1   = 3'h3,
    PH_T2   = 3'h2,
    PH_T3   = 3'h6,
    PH_TW   = 3'h7
  } embp_ph_t;

  // ==========================================================
  // Address and control pin group
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              space;
    logic              rw_n;
    logic              rd_n;
    logic              wr_n;
    logic              cs_n;
  } embp_pins_t;

  // ==========================================================
  // Whole state of the port
  typedef struct packed {
    embp_ph_t          ph;
    embp_pins_t        pins;
    logic              ctl_oe_n;
    logic              dat_oe_n;
    logic              req_oe_n;
    logic              gnt_oe_n;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] rdat;
    logic [WAIT_W-1:0] wcnt;
    logic              zw;
    logic              own;
    logic              grant;
    logic              br_n;
    logic              bb_n;
    logic              cap;
    logic              done;
    logic              ready;
    logic              bwait;
    logic              gsts;
    logic [1:0]        ta_s;
    logic [1:0]        br_s;
    logic [1:0]        bg_s;
    logic [1:0]        bb_s;
    logic [DATA_W-1:0] d_s1;
    logic [DATA_W-1:0] d_s2;
  } embp_st_t;

  // ==========================================================
  // Reset values: pins released except grant, strobes idle high
  // Synchronisers start at the idle pin level so no false request
  // or grant is seen; busy starts low so the bus counts as taken
  // until it has really been seen free
  localparam embp_pins_t PINS_RST = '{addr: '0, space: 1'b1,
    rw_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1};
  localparam embp_st_t ST_RST = '{ph: PH_IDLE, pins: PINS_RST,
    ctl_oe_n: 1'b1, dat_oe_n: 1'b1, br_n: 1'b1, bb_n: 1'b1,
    gsts: 1'b1, req_oe_n: 1'b1, ta_s: 2'b11, br_s: 2'b11,
    bg_s: 2'b11, default: '0};

endpackage

//--- testbench/embp_mem_mdl.sv
// Model of the external static memory and of a second bus master
module embp_mem_mdl (
  // Clock
  input  wire logic                        i_clk,
  // Port pins as seen from outside
  input  wire embp_pkg::embp_pins_t        i_pins,
  input  wire logic                        i_pins_oe_n,
  input  wire logic [embp_pkg::DATA_W-1:0] i_dut_d,
  input  wire logic                        i_dut_d_oe_n,
  // Behaviour knobs
  input  wire logic [3:0]                  i_ack_dly,
  input  wire logic                        i_want,
  input  wire logic                        i_grant_n,
  // Resolved data line and driven handshakes
  output logic      [embp_pkg::DATA_W-1:0] o_bus_d,
  output logic                             o_ack_n,
  output logic                             o_req_n,
  output logic                             o_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Memory
  logic [embp_pkg::DATA_W-1:0] mem [0:255];
  logic [embp_pkg::DATA_W-1:0] last_ff = '0;
  logic                        wr_ff = 1'b1;
  logic [3:0]                  cnt_ff = '0;
  logic                        own_ff = 1'b0;
  logic                        strb;
  assign strb = !i_pins_oe_n && !(i_pins.rd_n && i_pins.wr_n);
  // Nobody driving: line drifts, so stale data never looks valid
  always_comb begin
    if (!i_dut_d_oe_n) o_bus_d = i_dut_d;
    else if (!i_pins_oe_n && !i_pins.rd_n) o_bus_d = mem[i_pins.addr[7:0]];
    else o_bus_d = ~last_ff;
  end
  // Capture write data when the write strobe rises
  always_ff @(posedge i_clk) begin
    last_ff <= o_bus_d;
    wr_ff   <= i_pins.wr_n | i_pins_oe_n;
    cnt_ff  <= strb ? cnt_ff + 4'h1 : 4'h0;
    own_ff  <= i_want && !i_grant_n;
    if (!wr_ff && i_pins.wr_n && !i_pins_oe_n)
      mem[i_pins.addr[7:0]] <= o_bus_d;
  end
  // ack low after delay, freed with strobe; delay 0 holds it low throughout
  assign o_ack_n = (i_ack_dly != 4'h0) && !(strb && cnt_ff >= i_ack_dly);
  // busy held only while this master owns
  assign o_req_n  = !i_want;
  assign o_busy_n = !own_ff;
endmodule

//--- testbench/embp_port_bench.sv
// Self-checking bench of the external memory bus port
`define CHK(g, e) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
module embp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, wr = 1'b0, prog = 1'b0;
  logic lock = 1'b0, mm = 1'b0, rh = 1'b0, bg_drv = 1'b1, want = 1'b0;
  logic [15:0] addr = '0, wdata = '0, rdata, dout, dbus;
  logic [3:0] wcnt = '0, ack_dly = '0;
  logic ready, done, bwait, gsts, pins_oe_n, doe_n, ack_n, m_req, m_busy;
  logic req_o, req_oe, gnt_o, gnt_oe, bsy_o, bsy_oe, req_w, gnt_w, bsy_w;
  embp_pkg::embp_pins_t pins;
  embp_pkg::embp_pins_t tr_p [0:15];
  logic [3:0] tr_o [0:15];
  int errors = 0, n_checks = 0, cyc = 0, lat = 0;
  // Wired-AND arbitration lines with pull-ups
  assign req_w = (req_oe | req_o) & m_req;
  assign gnt_w = (gnt_oe | gnt_o) & bg_drv;
  assign bsy_w = (bsy_oe | bsy_o) & m_busy;
  always #2 clk = ~clk;
  embp_port i_embp_port (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .I_REQ_VALID(valid), .I_REQ_WRITE(wr), .I_REQ_PROG(prog),
    .I_REQ_ADDR(addr), .I_REQ_WDATA(wdata), .I_REQ_LOCK(lock),
    .O_REQ_READY(ready), .O_REQ_DONE(done), .O_REQ_RDATA(rdata),
    .O_BUS_WAIT(bwait), .I_WAIT_CNT(wcnt), .I_MASTER_MODE(mm),
    .I_REQUEST_HOLD(rh), .O_GRANT_STS(gsts), .O_PINS(pins),
    .O_PINS_OE_N(pins_oe_n), .I_DATA_BUS(dbus), .O_DATA_BUS(dout),
    .O_DATA_BUS_OE_N(doe_n), .I_TRANSFER_ACK_N(ack_n),
    .I_BUS_REQUEST_N(req_w), .O_BUS_REQUEST_N(req_o),
    .O_BUS_REQUEST_OE_N(req_oe), .I_BUS_GRANT_N(gnt_w),
    .O_BUS_GRANT_N(gnt_o), .O_BUS_GRANT_OE_N(gnt_oe),
    .I_BUS_BUSY_N(bsy_w), .O_BUS_BUSY_N(bsy_o), .O_BUS_BUSY_OE_N(bsy_oe));
  embp_mem_mdl i_embp_mem_mdl (.i_clk(clk), .i_pins(pins),
    .i_pins_oe_n(pins_oe_n), .i_dut_d(dout), .i_dut_d_oe_n(doe_n),
    .i_ack_dly(ack_dly), .i_want(want), .i_grant_n(gnt_w),
    .o_bus_d(dbus), .o_ack_n(ack_n), .o_req_n(m_req), .o_busy_n(m_busy));
  // ==========================================================
  // Verdict and hang guard
  task automatic end_sim();
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      end_sim();
    end
  end
  // One core access; traces pins from t0 until done
  task automatic acc(input logic w, input logic p, input logic [15:0] a,
                     input logic [15:0] d);
    int k;
    valid = 1'b1;
    wr = w;
    prog = p;
    addr = a;
    wdata = d;
    k = 0;
    do begin @(negedge clk); k++; end while (ready !== 1'b1 && k < 60);
    valid = 1'b0;
    lat = 0;
    while (done !== 1'b1 && lat < 40) begin
      if (lat < 16) tr_p[lat] = pins;
      if (lat < 16) tr_o[lat] = {pins_oe_n, doe_n, bsy_oe, bsy_o};
      @(negedge clk);
      lat++;
    end
    `CHK(k < 60 && lat < 40, 1'b1)
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_wr_rd();
    acc(1'b1, 1'b0, 16'h0012, 16'ha5c3);
    `CHK(lat, 4)
    `CHK({tr_p[0].addr, tr_p[0].space, tr_p[0].rw_n, tr_p[0].cs_n}, {16'h0012, 3'b000})
    `CHK({tr_p[1].wr_n, tr_p[2].wr_n, tr_p[3].wr_n}, 3'b001)
    `CHK({tr_p[1].cs_n, tr_p[2].cs_n}, 2'b01)
    `CHK({tr_o[1][2], tr_o[2][2], tr_o[3][2]}, 3'b100)
    `CHK(tr_o[0], 4'b0100)
    acc(1'b0, 1'b1, 16'h0012, 16'h0000);
    `CHK(lat, 5)
    `CHK(rdata, 16'ha5c3)
    `CHK({tr_p[0].space, tr_p[0].rw_n, tr_p[1].rd_n, tr_p[3].rd_n}, 4'b1101)
    repeat (3) @(negedge clk);
    `CHK({pins.addr, pins.space, pins.rw_n, pins.cs_n}, {16'h0012, 3'b111})
  endtask
  // Programmed and acknowledge waits: the longer one wins
  task automatic t_waits();
    logic [3:0] wt [3] = '{4'h2, 4'h0, 4'h2};
    logic [3:0] ad [3] = '{4'h0, 4'h5, 4'h8};
    int         el [3] = '{6, 11, 14};
    for (int i = 0; i < 3; i++) begin
      wcnt = wt[i];
      ack_dly = ad[i];
      // New acknowledge level must clear the synchroniser first
      repeat (3) @(negedge clk);
      acc(1'b1, 1'b0, 16'h0040, 16'h1234);
      `CHK(lat, el[i])
      `CHK({tr_p[lat - 3].cs_n, tr_p[lat - 2].cs_n}, 2'b01)
    end
    wcnt = 4'h0;
    ack_dly = 4'h0;
  endtask
  // Locked insn blocks grant; granted bus stalls the core
  task automatic t_slave();
    int k;
    lock = 1'b1;
    want = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(gnt_w, 1'b1)
    lock = 1'b0;
    k = 0;
    while (gnt_w !== 1'b0 && k < 20) begin @(negedge clk); k++; end
    repeat (4) @(negedge clk);
    `CHK({gnt_w, pins_oe_n, doe_n, bsy_oe, bsy_w}, 5'b01110)
    fork
      begin
        repeat (10) @(negedge clk);
        `CHK({bwait, ready}, 2'b10)
        want = 1'b0;
      end
      acc(1'b0, 1'b0, 16'h0040, 16'h0000);
    join
    `CHK({rdata, gnt_w}, {16'h1234, 1'b1})
  endtask
  // Master mode from reset: request, grant, hold, release
  task automatic t_master();
    rst = 1'b1;
    mm = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(gnt_oe, 1'b1)
    rst = 1'b0;
    fork
      begin
        repeat (8) @(negedge clk);
        `CHK({req_oe, req_w, bwait, gsts}, 4'b0011)
        bg_drv = 1'b0;
      end
      acc(1'b1, 1'b1, 16'h0077, 16'h5a5a);
    join
    `CHK({tr_o[0][1:0], gsts}, 3'b000)
    repeat (3) @(negedge clk);
    `CHK(req_w, 1'b1)
    rh = 1'b1;
    acc(1'b0, 1'b1, 16'h0077, 16'h0000);
    repeat (3) @(negedge clk);
    `CHK({req_w, rdata}, {1'b0, 16'h5a5a})
    bg_drv = 1'b1;
    repeat (8) @(negedge clk);
    `CHK({pins_oe_n, bsy_oe, gsts}, 3'b111)
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    `CHK({pins_oe_n, doe_n, bsy_oe, req_oe, gnt_oe}, 5'b11110)
    rst = 1'b0;
    repeat (6) @(negedge clk);
    t_wr_rd();
    t_waits();
    t_slave();
    t_master();
    end_sim();
  end
endmodule
